// ---- rtl/timer_pkg.sv ----
/*
  Shared constants of the multimode timer: register offsets, control field
  positions, reset values and the instruction-cycle divider.
  Assumes a 32-bit Avalon-MM register bus with byte addresses.
*/
package timer_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses, one aligned word each)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 5;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 5'h00;
  localparam logic [ADDR_W-1:0] OFF_TIMER = 5'h04;
  localparam logic [ADDR_W-1:0] OFF_RELOAD_A = 5'h08;
  localparam logic [ADDR_W-1:0] OFF_RELOAD_B = 5'h0c;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 5'h10;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int CTRL_RUN = 0;
  localparam int CTRL_MODE1 = 1;
  localparam int CTRL_MODE2 = 2;
  localparam int CTRL_MODE3 = 3;
  localparam int CTRL_IRQ_EN_A = 4;
  localparam int CTRL_IRQ_EN_B = 5;
  localparam int CTRL_PEND_A = 6;
  localparam int CTRL_PEND_B = 7;

  // ----------------------------------------------------------------
  // Status register fields
  // ----------------------------------------------------------------
  localparam int STAT_PIN_A = 0;
  localparam int STAT_PIN_B = 1;
  localparam int STAT_PWM_LEVEL = 2;
  localparam int STAT_PHASE_B = 3;

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [15:0] TIMER_RST = 16'h0000;
  localparam logic [15:0] RELOAD_RST = 16'h0000;
  localparam logic [15:0] TIMER_WRAP = 16'hffff;
  localparam int CLK_PERIOD_NS = 10;
  localparam int TC_DIV = 10;

endpackage

// ---- rtl/pin_edge_if.sv ----
/*
  Carrier of one synchronised timer pin: its level and edge pulses.
  Assumes driver and user share the single system clock.
*/
`timescale 1ns/10ps
interface pin_edge_if;
  logic level;
  logic rise;
  logic fall;
  modport det
  (
    output level,
    output rise,
    output fall
  );
  modport use_side
  (
    input level,
    input rise,
    input fall
  );
endinterface

// ---- rtl/pin_edge_sync.sv ----
/*
  Two-flop synchroniser and edge detector for one timer pin.
  Assumes the pin is asynchronous to i_mclk; pulses last one clock.
*/
`timescale 1ns/10ps
module pin_edge_sync
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_pin,
  pin_edge_if.det det
);

  logic meta;
  logic sync;
  logic prev;

  // ----------------------------------------------------------------
  // Synchroniser; only sync reads meta
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      meta <= 1'b0;
      sync <= 1'b0;
      prev <= 1'b0;
    end
    else
    begin
      meta <= i_pin;
      sync <= meta;
      prev <= sync;
    end
  end

  assign det.level = sync;
  assign det.rise = sync & ~prev;
  assign det.fall = ~sync & prev;

endmodule

// ---- rtl/multimode_timer_pwm_capture.sv ----
/*
  16-bit down-counting timer with two reload/capture registers: PWM,
  external event counter and input capture modes, Avalon-MM registers.
  Assumes pins are asynchronous and a bus master that holds its request
  until waitrequest is low.
*/
// The Avalon-MM register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
module multimode_timer_pwm_capture #(
  parameter int TC_DIV = timer_pkg::TC_DIV
)
(
  input wire logic I_MCLK,
  input wire logic I_RST,
  input wire logic [timer_pkg::ADDR_W-1:0] I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic [31:0] I_AVS_WRITEDATA,
  input wire logic [3:0] I_AVS_BYTEENABLE,
  output logic [31:0] O_AVS_READDATA,
  output logic O_AVS_WAITREQUEST,
  input wire logic I_TIMER_PIN_A,
  input wire logic I_TIMER_PIN_B,
  output logic O_TIMER_PIN_A,
  output logic O_TIMER_PIN_A_OE,
  output logic O_IRQ_A,
  output logic O_IRQ_B
);

  logic ack, acc, tick, uf, dec_en;
  logic [7:0] div_cnt;
  logic [15:0] main_timer, reload_capture_a, reload_capture_b;
  logic run_or_underflow_bit, mode_sel_bit1, mode_sel_bit2, mode_sel_bit3;
  logic irq_enable_a, irq_enable_b, pending_flag_a, pending_flag_b;
  logic phase_b, pwm_level, is_pwm, is_evt, is_cap, toggle_on, cnt_edge;
  logic cap_a, cap_b, set_a, set_b, wr_ctrl, wr_timer, wr_ra, wr_rb;
  logic [31:0] next_rdata;

  pin_edge_if edge_a(), edge_b();

  pin_edge_sync u_sync_a
  (
    .i_mclk(I_MCLK),
    .i_rst(I_RST),
    .i_pin(I_TIMER_PIN_A),
    .det(edge_a)
  );

  pin_edge_sync u_sync_b
  (
    .i_mclk(I_MCLK),
    .i_rst(I_RST),
    .i_pin(I_TIMER_PIN_B),
    .det(edge_b)
  );

  // ----------------------------------------------------------------
  // Byte-lane merge of a 16-bit register
  // ----------------------------------------------------------------
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [15:0] res;
    res = old;
    if (be[0])
      res[7:0] = wd[7:0];
    if (be[1])
      res[15:8] = wd[15:8];
    return res;
  endfunction

  // ----------------------------------------------------------------
  // Avalon-MM slave: one wait cycle, access completes on ack
  // ----------------------------------------------------------------
  assign O_AVS_WAITREQUEST = (I_AVS_READ | I_AVS_WRITE) & ~ack;
  assign acc = I_AVS_WRITE & ack;
  assign wr_ctrl = acc & (I_AVS_ADDRESS == timer_pkg::OFF_CTRL);
  assign wr_timer = acc & (I_AVS_ADDRESS == timer_pkg::OFF_TIMER);
  assign wr_ra = acc & (I_AVS_ADDRESS == timer_pkg::OFF_RELOAD_A);
  assign wr_rb = acc & (I_AVS_ADDRESS == timer_pkg::OFF_RELOAD_B);

  always_ff @(posedge I_MCLK or posedge I_RST)
  begin
    if (I_RST)
      ack <= 1'b0;
    else
      ack <= (I_AVS_READ | I_AVS_WRITE) & ~ack;
  end

  always_comb
  begin
    next_rdata = 32'h0000_0000;
    unique case (I_AVS_ADDRESS)
      timer_pkg::OFF_CTRL:
      begin
        next_rdata[timer_pkg::CTRL_RUN] = run_or_underflow_bit;
        next_rdata[timer_pkg::CTRL_MODE1] = mode_sel_bit1;
        next_rdata[timer_pkg::CTRL_MODE2] = mode_sel_bit2;
        next_rdata[timer_pkg::CTRL_MODE3] = mode_sel_bit3;
        next_rdata[timer_pkg::CTRL_IRQ_EN_A] = irq_enable_a;
        next_rdata[timer_pkg::CTRL_IRQ_EN_B] = irq_enable_b;
        next_rdata[timer_pkg::CTRL_PEND_A] = pending_flag_a;
        next_rdata[timer_pkg::CTRL_PEND_B] = pending_flag_b;
      end
      timer_pkg::OFF_TIMER: next_rdata[15:0] = main_timer;
      timer_pkg::OFF_RELOAD_A: next_rdata[15:0] = reload_capture_a;
      timer_pkg::OFF_RELOAD_B: next_rdata[15:0] = reload_capture_b;
      timer_pkg::OFF_STATUS:
      begin
        next_rdata[timer_pkg::STAT_PIN_A] = edge_a.level;
        next_rdata[timer_pkg::STAT_PIN_B] = edge_b.level;
        next_rdata[timer_pkg::STAT_PWM_LEVEL] = pwm_level;
        next_rdata[timer_pkg::STAT_PHASE_B] = phase_b;
      end
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // Data captured as the wait cycle ends, stable on the completing edge
  always_ff @(posedge I_MCLK or posedge I_RST)
  begin
    if (I_RST)
      O_AVS_READDATA <= 32'h0000_0000;
    else if (I_AVS_READ & ~ack)
      O_AVS_READDATA <= next_rdata;
  end

  // ----------------------------------------------------------------
  // Instruction-cycle enable
  // ----------------------------------------------------------------
  always_ff @(posedge I_MCLK or posedge I_RST)
  begin
    if (I_RST)
      div_cnt <= 8'h00;
    else
      div_cnt <= tick ? 8'h00 : div_cnt + 8'h01;
  end

  assign tick = (div_cnt == 8'(TC_DIV - 1));

  // ----------------------------------------------------------------
  // Mode decode and count enable
  // ----------------------------------------------------------------
  assign is_pwm = mode_sel_bit3 & ~mode_sel_bit2;
  assign is_evt = ~mode_sel_bit3 & ~mode_sel_bit2;
  assign is_cap = mode_sel_bit2;
  assign toggle_on = is_pwm & mode_sel_bit1;
  assign cnt_edge = mode_sel_bit1 ? edge_a.fall : edge_a.rise;
  assign cap_a = is_cap & (mode_sel_bit1 ? edge_a.fall : edge_a.rise);
  assign cap_b = is_cap & ((mode_sel_bit1 | mode_sel_bit3) ? edge_b.fall : edge_b.rise);

  assign dec_en = is_pwm ? (run_or_underflow_bit & tick)
    : (is_evt ? (run_or_underflow_bit & cnt_edge) : tick);

  assign uf = dec_en & (main_timer == 16'h0000) & ~wr_timer;

  // ----------------------------------------------------------------
  // Main timer and reload/capture registers
  // ----------------------------------------------------------------
  always_ff @(posedge I_MCLK or posedge I_RST)
  begin
    if (I_RST)
      main_timer <= timer_pkg::TIMER_RST;
    else if (wr_timer)
      main_timer <= merge16(main_timer, I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
    else if (uf & is_pwm)
      main_timer <= phase_b ? reload_capture_b : reload_capture_a;
    else if (uf & is_evt)
      main_timer <= reload_capture_a;
    else if (uf)
      main_timer <= timer_pkg::TIMER_WRAP;
    else if (dec_en)
      main_timer <= main_timer - 16'h0001;
  end

  // Capture beats a same-cycle software write: the event time matters more
  always_ff @(posedge I_MCLK or posedge I_RST)
  begin
    if (I_RST)
      reload_capture_a <= timer_pkg::RELOAD_RST;
    else if (cap_a)
      reload_capture_a <= main_timer;
    else if (wr_ra)
      reload_capture_a <= merge16(reload_capture_a, I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
  end

  always_ff @(posedge I_MCLK or posedge I_RST)
  begin
    if (I_RST)
      reload_capture_b <= timer_pkg::RELOAD_RST;
    else if (cap_b)
      reload_capture_b <= main_timer;
    else if (wr_rb)
      reload_capture_b <= merge16(reload_capture_b, I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
  end

  // Writing the timer restarts the alternation at register A
  always_ff @(posedge I_MCLK or posedge I_RST)
  begin
    if (I_RST)
      phase_b <= 1'b0;
    else if (wr_timer | ~is_pwm)
      phase_b <= 1'b0;
    else if (uf)
      phase_b <= ~phase_b;
  end

  // ----------------------------------------------------------------
  // PWM pin
  // ----------------------------------------------------------------
  always_ff @(posedge I_MCLK or posedge I_RST)
  begin
    if (I_RST)
      pwm_level <= 1'b0;
    else if (toggle_on & uf)
      pwm_level <= ~pwm_level;
  end

  assign O_TIMER_PIN_A = pwm_level;
  assign O_TIMER_PIN_A_OE = toggle_on;

  // ----------------------------------------------------------------
  // Control bits and pending flags; hardware set beats software clear
  // ----------------------------------------------------------------
  assign set_a = (is_pwm & uf & ~phase_b) | (is_evt & uf) | cap_a;
  assign set_b = (is_pwm & uf & phase_b) | (is_evt & edge_b.rise) | cap_b;

  always_ff @(posedge I_MCLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      mode_sel_bit1 <= 1'b0;
      mode_sel_bit2 <= 1'b0;
      mode_sel_bit3 <= 1'b0;
      irq_enable_a <= 1'b0;
      irq_enable_b <= 1'b0;
    end
    else if (wr_ctrl & I_AVS_BYTEENABLE[0])
    begin
      mode_sel_bit1 <= I_AVS_WRITEDATA[timer_pkg::CTRL_MODE1];
      mode_sel_bit2 <= I_AVS_WRITEDATA[timer_pkg::CTRL_MODE2];
      mode_sel_bit3 <= I_AVS_WRITEDATA[timer_pkg::CTRL_MODE3];
      irq_enable_a <= I_AVS_WRITEDATA[timer_pkg::CTRL_IRQ_EN_A];
      irq_enable_b <= I_AVS_WRITEDATA[timer_pkg::CTRL_IRQ_EN_B];
    end
  end

  always_ff @(posedge I_MCLK or posedge I_RST)
  begin
    if (I_RST)
      run_or_underflow_bit <= 1'b0;
    else if (is_cap & uf)
      run_or_underflow_bit <= 1'b1;
    else if (wr_ctrl & I_AVS_BYTEENABLE[0])
      run_or_underflow_bit <= I_AVS_WRITEDATA[timer_pkg::CTRL_RUN];
  end

  always_ff @(posedge I_MCLK or posedge I_RST)
  begin
    if (I_RST)
      pending_flag_a <= 1'b0;
    else if (set_a)
      pending_flag_a <= 1'b1;
    else if (wr_ctrl & I_AVS_BYTEENABLE[0])
      pending_flag_a <= I_AVS_WRITEDATA[timer_pkg::CTRL_PEND_A];
  end

  always_ff @(posedge I_MCLK or posedge I_RST)
  begin
    if (I_RST)
      pending_flag_b <= 1'b0;
    else if (set_b)
      pending_flag_b <= 1'b1;
    else if (wr_ctrl & I_AVS_BYTEENABLE[0])
      pending_flag_b <= I_AVS_WRITEDATA[timer_pkg::CTRL_PEND_B];
  end

  // ----------------------------------------------------------------
  // Interrupt requests
  // ----------------------------------------------------------------
  assign O_IRQ_A = irq_enable_a & (pending_flag_a | (is_cap & run_or_underflow_bit));
  assign O_IRQ_B = irq_enable_b & pending_flag_b;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge I_MCLK);
  endclocking
  default disable iff (I_RST);

  sequence s_uf_a;
    is_pwm && uf && !phase_b && !wr_ctrl;
  endsequence
  sequence s_reload_a;
    main_timer == $past(reload_capture_a) && phase_b && pending_flag_a;
  endsequence

  property p_pwm_rate;
    is_pwm && run_or_underflow_bit && !tick && !wr_timer |=> main_timer == $past(main_timer);
  endproperty
  a_pwm_rate: assert property (p_pwm_rate) else $error("PWM count moved without tick");
  property p_reload_alt;
    s_uf_a |=> s_reload_a;
  endproperty
  a_reload_alt: assert property (p_reload_alt) else $error("PWM reload A missing");
  property p_toggle;
    toggle_on && uf ##1 toggle_on |-> O_TIMER_PIN_A != $past(O_TIMER_PIN_A) && O_TIMER_PIN_A_OE;
  endproperty
  a_toggle: assert property (p_toggle) else $error("Pin A did not toggle");
  property p_pend_b;
    is_pwm && uf && phase_b |=> pending_flag_b && !phase_b;
  endproperty
  a_pend_b: assert property (p_pend_b) else $error("Pending B not set on B reload");
  property p_irq_mask;
    !irq_enable_b |-> !O_IRQ_B;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("Masked interrupt B raised");
  property p_evt_count;
    is_evt && run_or_underflow_bit && cnt_edge && main_timer != 16'h0000 && !wr_timer
      |=> main_timer == $past(main_timer) - 16'h0001;
  endproperty
  a_evt_count: assert property (p_evt_count) else $error("Event edge not counted");
  // Raw mode bits, so a wrong mode decode is caught as well
  property p_evt_no_drive;
    !mode_sel_bit3 && !mode_sel_bit2 |-> !O_TIMER_PIN_A_OE;
  endproperty
  a_evt_no_drive: assert property (p_evt_no_drive) else $error("Pin A driven in event mode");
  property p_capture;
    cap_a |=> reload_capture_a == $past(main_timer) && pending_flag_a;
  endproperty
  a_capture: assert property (p_capture) else $error("Capture A lost");
  property p_cap_uf;
    is_cap && uf && !wr_timer |=> run_or_underflow_bit && main_timer == 16'hffff;
  endproperty
  a_cap_uf: assert property (p_cap_uf) else $error("Capture underflow not flagged");
  property p_hold;
    (is_pwm || is_evt) && !run_or_underflow_bit && !wr_timer |=> $stable(main_timer);
  endproperty
  a_hold: assert property (p_hold) else $error("Stopped timer moved");
  property p_bus;
    (I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST |=> !O_AVS_WAITREQUEST;
  endproperty
  a_bus: assert property (p_bus) else $error("Waitrequest held over one cycle");

endmodule

// ---- tb/pin_partner.sv ----
/*
  Far side of the timer: the two external timer pins.
  Assumes callers step it right after a rising clock edge.
*/
`timescale 1ns/10ps
module pin_partner
(
  input wire logic i_mclk,
  input wire logic i_drv_a,
  input wire logic i_oe_a,
  output logic o_pin_a,
  output logic o_pin_b
);
  logic lvl_a = 1'b0;
  logic lvl_b = 1'b0;

  // Pin A belongs to the timer while it drives it, so no contention
  assign o_pin_a = i_oe_a ? i_drv_a : lvl_a;
  assign o_pin_b = lvl_b;

  // Long hold so every level clears the two-flop synchroniser
  task automatic set_pin(input bit sel_b, input logic val);
    if (sel_b)
    begin
      lvl_b <= val;
    end
    else
    begin
      lvl_a <= val;
    end
    repeat (8) @(posedge i_mclk);
  endtask
endmodule

// ---- tb/testbench.sv ----
/*
  Self-checking bench of the multimode timer: register bus, PWM, event
  counter and capture modes. Assumes the pin partner model beside it.
*/
`timescale 1ns/10ps
module testbench;
  localparam int DIV = 2;
  typedef struct {logic [31:0] exp; logic [31:0] mask;} note_t;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [timer_pkg::ADDR_W-1:0] adr = '0;
  logic rd_en = 1'b0;
  logic wr_en = 1'b0;
  logic [31:0] wdata = '0;
  logic [3:0] be = 4'hf;
  logic [31:0] rdata;
  logic waitreq, pin_a_out, pin_a_oe, irq_a, irq_b, pin_a, pin_b;
  int errors = 0;
  int checks_done = 0;
  int n, ra, rb;
  note_t notes[$];
  logic [31:0] q, t0, t1, ca;
  logic [31:0] cm [4] = '{32'h34, 32'h3c, 32'h36, 32'h3e};
  bit ea [4] = '{1, 1, 0, 0};
  bit eb [4] = '{1, 0, 0, 0};
  logic lv [8] = '{1, 0, 1, 0, 1, 0, 1, 0};
  logic [31:0] et [8] = '{2, 2, 2, 1, 1, 0, 0, 7};

  multimode_timer_pwm_capture #(.TC_DIV(DIV)) u_dut
  (
    .I_MCLK(mclk), .I_RST(rst), .I_AVS_ADDRESS(adr), .I_AVS_READ(rd_en), .I_AVS_WRITE(wr_en),
    .I_AVS_WRITEDATA(wdata), .I_AVS_BYTEENABLE(be), .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(waitreq),
    .I_TIMER_PIN_A(pin_a), .I_TIMER_PIN_B(pin_b), .O_TIMER_PIN_A(pin_a_out), .O_TIMER_PIN_A_OE(pin_a_oe),
    .O_IRQ_A(irq_a), .O_IRQ_B(irq_b)
  );
  pin_partner u_pins
  (
    .i_mclk(mclk), .i_drv_a(pin_a_out), .i_oe_a(pin_a_oe), .o_pin_a(pin_a), .o_pin_b(pin_b)
  );

  initial forever #5 mclk = ~mclk;

  // ----------------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------------
  task automatic cmp(input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  task automatic cmp_rd(input note_t nt, input logic [31:0] got);
    checks_done++;
    if ((got & nt.mask) !== (nt.exp & nt.mask))
    begin
      errors++;
      $display("[FAIL] t=%0t read exp=%h got=%h", $time, nt.exp & nt.mask, got & nt.mask);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Holds the request until waitrequest is seen low at a rising edge
  task automatic bus(input bit w, input logic [4:0] a, input logic [31:0] d, input logic [3:0] b,
                     output logic [31:0] r);
    adr <= a;
    wdata <= d;
    be <= b;
    wr_en <= w;
    rd_en <= !w;
    // Only the watchdog ends a wait that never completes
    do
      @(posedge mclk);
    while (waitreq !== 1'b0);
    r = rdata;
    rd_en <= 1'b0;
    wr_en <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, 4'hf, r);
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m);
    logic [31:0] r;
    notes.push_back('{e, m});
    bus(1'b0, a, 32'h0, 4'hf, r);
  endtask

  // Value wanted by the driver itself; its note carries no check
  task automatic rdv(input logic [4:0] a, output logic [31:0] r);
    notes.push_back('{32'h0, 32'h0});
    bus(1'b0, a, 32'h0, 4'hf, r);
  endtask

  task automatic wait_tog(output int c);
    logic l;
    c = 0;
    l = pin_a_out;
    do
    begin
      @(posedge mclk);
      c++;
    end
    while (pin_a_out === l && c < 500);
    if (c >= 500)
      errors++;
  endtask

  always @(posedge mclk)
  begin
    if (rd_en && waitreq === 1'b0 && notes.size() > 0)
    begin
      if (notes[0].mask !== 32'h0)
        cmp_rd(notes[0], rdata);
      void'(notes.pop_front());
    end
  end

  initial
  begin
    repeat (20000) @(posedge mclk);
    errors++;
    wrap_up();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial
  begin
    void'($urandom(32'h067d));
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rd(timer_pkg::OFF_CTRL, 32'h0, 32'hffffffff);
    rd(timer_pkg::OFF_TIMER, 32'h0, 32'hffffffff);
    rd(timer_pkg::OFF_RELOAD_A, 32'h0, 32'hffffffff);
    wr(timer_pkg::OFF_STATUS, 32'hffffffff);
    rd(timer_pkg::OFF_STATUS, 32'h0, 32'hffffffff);
    rd(5'h14, 32'h0, 32'hffffffff);
    wr(timer_pkg::OFF_RELOAD_B, 32'hdeadbeef);
    rd(timer_pkg::OFF_RELOAD_B, 32'h0000beef, 32'hffffffff);
    bus(1'b1, timer_pkg::OFF_RELOAD_B, 32'h12, 4'h1, q);
    rd(timer_pkg::OFF_RELOAD_B, 32'h0000be12, 32'hffffffff);
    $display("test registers done");

    ra = 2 + int'($urandom_range(7));
    rb = 2 + int'($urandom_range(7));
    wr(timer_pkg::OFF_RELOAD_A, 32'(ra));
    wr(timer_pkg::OFF_RELOAD_B, 32'(rb));
    wr(timer_pkg::OFF_TIMER, 32'h1);
    wr(timer_pkg::OFF_CTRL, 32'h1b);
    wait_tog(n);
    cmp(32'h1, 32'(pin_a_out));
    cmp(32'h1, 32'(pin_a_oe));
    wait_tog(n);
    cmp(32'((ra + 1) * DIV), 32'(n));
    wait_tog(n);
    cmp(32'((rb + 1) * DIV), 32'(n));
    wait_tog(n);
    cmp(32'((ra + 1) * DIV), 32'(n));
    cmp(32'h1, 32'(irq_a));
    cmp(32'h0, 32'(irq_b));
    rd(timer_pkg::OFF_CTRL, 32'hdb, 32'hff);
    wr(timer_pkg::OFF_CTRL, 32'h2a);
    cmp(32'h0, 32'(irq_a));
    rdv(timer_pkg::OFF_TIMER, t0);
    repeat (20) @(posedge mclk);
    rdv(timer_pkg::OFF_TIMER, t1);
    cmp(t0, t1);
    wr(timer_pkg::OFF_CTRL, 32'h2b);
    wait_tog(n);
    wait_tog(n);
    cmp(32'h1, 32'(irq_b));
    cmp(32'h0, 32'(irq_a));
    wr(timer_pkg::OFF_CTRL, 32'h09);
    cmp(32'h0, 32'(pin_a_oe));
    $display("test pwm done");

    // Leave PWM first, or the count moves before the event phase starts
    wr(timer_pkg::OFF_CTRL, 32'h31);
    wr(timer_pkg::OFF_RELOAD_A, 32'h7);
    wr(timer_pkg::OFF_TIMER, 32'h3);
    cmp(32'h0, 32'(pin_a_oe));
    for (int i = 0; i < 8; i++)
    begin
      if (i == 2)
        wr(timer_pkg::OFF_CTRL, 32'h33);
      u_pins.set_pin(1'b0, lv[i]);
      rd(timer_pkg::OFF_TIMER, et[i], 32'hffff);
    end
    cmp(32'h1, 32'(irq_a));
    rd(timer_pkg::OFF_CTRL, 32'h73, 32'hff);
    u_pins.set_pin(1'b1, 1'b1);
    rd(timer_pkg::OFF_CTRL, 32'hf3, 32'hff);
    cmp(32'h1, 32'(irq_b));
    u_pins.set_pin(1'b1, 1'b0);
    $display("test event done");

    wr(timer_pkg::OFF_TIMER, 32'h8000);
    for (int i = 0; i < 4; i++)
    begin
      u_pins.set_pin(1'b0, !ea[i]);
      u_pins.set_pin(1'b1, !eb[i]);
      wr(timer_pkg::OFF_CTRL, cm[i]);
      rdv(timer_pkg::OFF_TIMER, t0);
      u_pins.set_pin(1'b0, ea[i]);
      rdv(timer_pkg::OFF_RELOAD_A, ca);
      cmp(32'h1, 32'(t0 >= ca && t0 - ca <= 8));
      rd(timer_pkg::OFF_CTRL, cm[i] | 32'h40, 32'hff);
      cmp(32'h1, 32'(irq_a));
      u_pins.set_pin(1'b1, eb[i]);
      rd(timer_pkg::OFF_CTRL, cm[i] | 32'hc0, 32'hff);
      cmp(32'h1, 32'(irq_b));
      wr(timer_pkg::OFF_CTRL, cm[i]);
      u_pins.set_pin(1'b0, !ea[i]);
      u_pins.set_pin(1'b1, !eb[i]);
      rd(timer_pkg::OFF_CTRL, cm[i], 32'hff);
      rd(timer_pkg::OFF_RELOAD_A, ca, 32'hffff);
    end
    rdv(timer_pkg::OFF_TIMER, t0);
    repeat (7) @(posedge mclk);
    rdv(timer_pkg::OFF_TIMER, t1);
    cmp(32'(10 / DIV), t0 - t1);
    wr(timer_pkg::OFF_TIMER, 32'h2);
    repeat (20) @(posedge mclk);
    rd(timer_pkg::OFF_CTRL, 32'h01, 32'h41);
    cmp(32'h1, 32'(irq_a));
    rd(timer_pkg::OFF_TIMER, 32'hf000, 32'hf000);
    $display("test capture done");
    wrap_up();
  end
endmodule
